// *** common/pfss_defines.svh ***
`ifndef PFSS_DEFINES_SVH
`define PFSS_DEFINES_SVH
// clock rate used to turn times into cycle counts
`define PFSS_CLK_MHZ   10
// ground diode current persistence
`define PFSS_GND_US    200
`define PFSS_GND_CYC   (`PFSS_GND_US * `PFSS_CLK_MHZ)
// zero-crossing watchdog
`define PFSS_WD_US     200
`define PFSS_WD_CYC    (`PFSS_WD_US * `PFSS_CLK_MHZ)
// fault input blanking delay
`define PFSS_FLT_US    30
`define PFSS_FLT_CYC   (`PFSS_FLT_US * `PFSS_CLK_MHZ)
// standby blank time after regulation ok rises
`define PFSS_BLANK_MS  1
`define PFSS_BLANK_CYC (`PFSS_BLANK_MS * 1000 * `PFSS_CLK_MHZ)
// line removal timer
`define PFSS_RMV_MS    100
`define PFSS_RMV_CYC   (`PFSS_RMV_MS * 1000 * `PFSS_CLK_MHZ)
// filter capacitor discharge / line check window
`define PFSS_DIS_MS    32
`define PFSS_DIS_CYC   (`PFSS_DIS_MS * 1000 * `PFSS_CLK_MHZ)
// line sample interval in cycles
`define PFSS_SMP_CYC   1000
// register byte offsets and control reset value
`define PFSS_CTRL_OFS  4'h0
`define PFSS_STAT_OFS  4'h4
`define PFSS_CTRL_RST  1'h1
`endif

// *** common/pfss_pkg.sv ***
package pfss_pkg;
    // line removal sequencer states, one-hot
    typedef enum logic [4:0] {
        LR_RUN = 5'h01,  // line present, normal supervision
        LR_X2  = 5'h02,  // filter capacitor discharge
        LR_CHK = 5'h04,  // line return check window
        LR_VCC = 5'h08,  // supply capacitor sink
        LR_WON = 5'h10   // wait for supply turn-on level
    } pfss_lr_t;
endpackage

// *** rtl/pfss_top.sv ***
`timescale 1ns/1ps
`include "pfss_defines.svh"
module pfss_top #(
    parameter int BLANK_CYC = `PFSS_BLANK_CYC, // standby blank
    parameter int RMV_CYC   = `PFSS_RMV_CYC,   // removal timer
    parameter int DIS_CYC   = `PFSS_DIS_CYC,   // discharge window
    parameter int LW        = 10               // line code width
) (
    input  wire logic          clk,            // 10 MHz clock
    input  wire logic          reset_n,        // sync reset
    input  wire logic [3:0]    avs_address,    // byte address
    input  wire logic          avs_read,       // read request
    input  wire logic          avs_write,      // write request
    input  wire logic [31:0]   avs_writedata,  // write data
    input  wire logic [3:0]    avs_byteenable, // byte lanes
    output logic [31:0]        avs_readdata,   // read data
    output logic               avs_waitrequest,// hold master
    input  wire logic          gnd_diode_cur,  // ground diode current
    input  wire logic          sense_at_rail,  // sense pin at rail
    input  wire logic          sense_above_arm,// above arm threshold
    input  wire logic          overstress,     // diode short sensed
    input  wire logic          fault_above_thr,// fault input high
    input  wire logic          standby_below,  // standby input low
    input  wire logic          bulk_below_rst, // bulk below restart
    input  wire logic          ota_in_reg,     // amp current <= 0
    input  wire logic          bulk_above_uv,  // bulk above uv
    input  wire logic          brownout,       // brownout seen
    input  wire logic          supply_reset,   // supply at reset
    input  wire logic          supply_on,      // supply at turn-on
    input  wire logic          supply_low,     // supply below 5 V
    input  wire logic          x2_low,         // filter cap < 30 V
    input  wire logic          uvlo,           // undervoltage lockout
    input  wire logic [LW-1:0] line_code,      // line sample, clk dom
    output logic               drive_en,       // gate drive allowed
    output logic               low_duty,       // force low duty
    output logic               pullup_en,      // 250 uA pull-up on
    output logic               regulation_ok,  // regulation ok
    output logic               x2_discharge,   // filter cap discharge
    output logic               supply_sink     // supply cap sink
);
    import pfss_pkg::*;

    localparam int NF = 15;
    localparam logic [23:0] GND_L   = 24'(`PFSS_GND_CYC - 1);
    localparam logic [23:0] WD_L    = 24'(`PFSS_WD_CYC - 1);
    localparam logic [23:0] FLT_L   = 24'(`PFSS_FLT_CYC);
    localparam logic [23:0] BLANK_L = 24'(BLANK_CYC - 1);
    localparam logic [23:0] RMV_L   = 24'(RMV_CYC - 1);
    localparam logic [23:0] DIS_L   = 24'(DIS_CYC - 1);
    localparam logic [23:0] SMP_L   = 24'(`PFSS_SMP_CYC - 1);

    // saturating counter step
    function automatic logic [23:0] inc_sat(input logic [23:0] c);
        return (c == 24'hffffff) ? c : c + 24'h1;
    endfunction

    // ---- flag synchroniser: three stages, second/third agree
    logic [NF-1:0] raw_w;        // pin flags
    logic [NF-1:0] s1_r;         // first stage
    logic [NF-1:0] s2_r;         // second stage
    logic [NF-1:0] s3_r;         // third stage
    logic [NF-1:0] flg_r;        // accepted flags
    logic f_gnd, f_rail, f_arm, f_ovs, f_flt, f_stby, f_blow;
    logic f_inreg, f_buv, f_bo, f_vrst, f_von, f_vlow, f_x2l;
    logic f_uvlo;
    assign raw_w = {gnd_diode_cur, sense_at_rail, sense_above_arm,
                    overstress, fault_above_thr, standby_below,
                    bulk_below_rst, ota_in_reg, bulk_above_uv,
                    brownout, supply_reset, supply_on, supply_low,
                    x2_low, uvlo};
    assign {f_gnd, f_rail, f_arm, f_ovs, f_flt, f_stby, f_blow,
            f_inreg, f_buv, f_bo, f_vrst, f_von, f_vlow, f_x2l,
            f_uvlo} = flg_r;

    // three flops, change accepted only when stages agree
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s1_r  <= '0;
            s2_r  <= '0;
            s3_r  <= '0;
            flg_r <= '0;
        end else begin
            s1_r  <= raw_w;
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            flg_r <= (s2_r & s3_r) | (flg_r & (s2_r ^ s3_r));
        end
    end

    // ---- registers and bus state
    logic        en_r;           // software controller enable
    logic        wait_r;         // waitrequest flop
    logic [31:0] rdata_r;        // read data flop
    logic        acc_w;          // access this edge
    logic        hit_ctrl_w;     // control offset decode
    logic        hit_stat_w;     // status offset decode
    logic [31:0] rmux_w;         // read mux
    logic [31:0] stat_w;         // status word

    // ---- supervision state
    logic [23:0] gnd_cnt_r;      // ground diode persistence
    logic        gnd_fault_r;    // open ground fault
    logic [23:0] wd_cnt_r;       // zero-crossing watchdog
    logic        arm_d_r;        // delayed arm flag
    logic        zc_edge_w;      // zero-crossing transition
    logic        pullup_r;       // pull-up applied
    logic        armed_r;        // sense pin armed
    logic [23:0] flt_cnt_r;      // fault input blanking
    logic        fault_latch_r;  // latched fault
    logic        reg_ok_r;       // regulation ok
    logic [23:0] blank_cnt_r;    // standby blank
    logic        blank_done_w;   // blank elapsed
    logic        stby_act_r;     // standby mode
    logic        burst_off_r;    // burst off interval
    logic        ctrl_ok_w;      // controller enabled
    logic        drv_r;          // gate drive allowed
    logic        low_duty_r;     // low duty forced

    // ---- line removal state
    logic [23:0] smp_cnt_r;      // sample divider
    logic        tick_w;         // sample enable pulse
    logic [LW-1:0] prev_r;       // previous line sample
    logic        pos_w;          // positive slope seen
    logic [23:0] rmv_cnt_r;      // removal timer
    logic [23:0] dis_cnt_r;      // discharge window timer
    pfss_lr_t    lr_r;           // sequencer state
    pfss_lr_t    lr_nxt;         // next state
    logic        x2_r;           // filter discharge on
    logic        sink_r;         // supply sink on

    // ---- bus decode
    assign acc_w      = (avs_read | avs_write) & wait_r;
    assign hit_ctrl_w = (avs_address == `PFSS_CTRL_OFS);
    assign hit_stat_w = (avs_address == `PFSS_STAT_OFS);
    assign stat_w     = {17'h0, lr_r, burst_off_r, stby_act_r,
                         armed_r, pullup_r, gnd_fault_r,
                         fault_latch_r, drv_r, reg_ok_r, low_duty_r,
                         sink_r};
    assign rmux_w     = hit_ctrl_w ? {31'h0, en_r} :
                        hit_stat_w ? stat_w : 32'h0;

    // one wait cycle, then a single-cycle answer
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            wait_r  <= 1'h1;
            rdata_r <= 32'h0;
        end else begin
            wait_r  <= ~acc_w;
            if (avs_read && wait_r) begin
                rdata_r <= rmux_w;
            end
        end
    end

    // control write takes effect as waitrequest is low
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            en_r <= `PFSS_CTRL_RST;
        end else if (avs_write && !wait_r && hit_ctrl_w &&
                     avs_byteenable[0]) begin
            en_r <= avs_writedata[0];
        end
    end

    // ---- open ground detect, sticky until supply reset
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            gnd_cnt_r   <= 24'h0;
            gnd_fault_r <= 1'h0;
        end else begin
            gnd_cnt_r <= f_gnd ? inc_sat(gnd_cnt_r) : 24'h0;
            if (f_gnd && gnd_cnt_r >= GND_L) begin
                gnd_fault_r <= 1'h1;
            end else if (f_vrst) begin
                gnd_fault_r <= 1'h0;
            end
        end
    end

    // ---- zero-crossing watchdog and pull-up
    assign zc_edge_w = f_arm & ~arm_d_r;
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            arm_d_r  <= 1'h0;
            wd_cnt_r <= 24'h0;
            pullup_r <= 1'h0;
        end else begin
            arm_d_r  <= f_arm;
            wd_cnt_r <= zc_edge_w ? 24'h0 : inc_sat(wd_cnt_r);
            if (zc_edge_w) begin
                pullup_r <= 1'h0;
            end else if (wd_cnt_r == WD_L) begin
                pullup_r <= 1'h1;
            end
        end
    end

    // arming: lost on watchdog expiry, regained above threshold
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            armed_r <= 1'h0;
        end else if (f_arm) begin
            armed_r <= 1'h1;
        end else if (wd_cnt_r == WD_L) begin
            armed_r <= 1'h0;
        end
    end

    // ---- fault input blanking and latch; pin floats high
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            flt_cnt_r     <= 24'h0;
            fault_latch_r <= 1'h0;
        end else begin
            flt_cnt_r <= f_flt ? inc_sat(flt_cnt_r) : 24'h0;
            if (f_flt && flt_cnt_r >= FLT_L) begin
                fault_latch_r <= 1'h1;
            end else if (f_bo || f_vrst) begin
                fault_latch_r <= 1'h0;
            end
        end
    end

    // ---- controller enable and regulation ok
    assign ctrl_ok_w = en_r & ~gnd_fault_r & ~f_rail & ~f_uvlo &
                       ~fault_latch_r & ~f_bo & (lr_r == LR_RUN);
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            reg_ok_r <= 1'h0;
        end else begin
            reg_ok_r <= ctrl_ok_w & f_buv & (reg_ok_r | f_inreg);
        end
    end

    // ---- standby blanking and burst control
    assign blank_done_w = (blank_cnt_r >= BLANK_L);
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            blank_cnt_r <= 24'h0;
            stby_act_r  <= 1'h0;
            burst_off_r <= 1'h0;
        end else begin
            blank_cnt_r <= reg_ok_r ? inc_sat(blank_cnt_r) : 24'h0;
            stby_act_r  <= reg_ok_r & blank_done_w & f_stby;
            // off until bulk sags below restart, on until in reg
            burst_off_r <= stby_act_r &
                           (burst_off_r ? ~f_blow : f_inreg);
        end
    end

    // ---- gate drive and low duty outputs
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            drv_r      <= 1'h0;
            low_duty_r <= 1'h0;
        end else begin
            drv_r      <= ctrl_ok_w & armed_r & ~burst_off_r;
            low_duty_r <= f_ovs;
        end
    end

    // ---- line sampling and slope detection
    assign tick_w = (smp_cnt_r == SMP_L);
    assign pos_w  = tick_w & (line_code > prev_r);
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            smp_cnt_r <= 24'h0;
            prev_r    <= '0;
        end else begin
            smp_cnt_r <= tick_w ? 24'h0 : smp_cnt_r + 24'h1;
            if (tick_w) begin
                prev_r <= line_code;
            end
        end
    end

    // removal timer runs only in LR_RUN while slope not positive
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rmv_cnt_r <= 24'h0;
        end else if (pos_w || lr_r != LR_RUN) begin
            rmv_cnt_r <= 24'h0;
        end else begin
            rmv_cnt_r <= inc_sat(rmv_cnt_r);
        end
    end

    // ---- line removal sequencer
    always_comb begin
        lr_nxt = lr_r;
        unique case (lr_r)
            LR_RUN: begin
                if (rmv_cnt_r >= RMV_L && !pos_w) begin
                    lr_nxt = LR_X2;
                end
            end
            LR_X2: begin
                if (pos_w || f_x2l) begin
                    lr_nxt = LR_VCC;
                end else if (dis_cnt_r >= DIS_L) begin
                    lr_nxt = LR_CHK;
                end
            end
            LR_CHK: begin
                if (pos_w || f_x2l) begin
                    lr_nxt = LR_VCC;
                end else if (dis_cnt_r >= DIS_L) begin
                    lr_nxt = LR_X2;
                end
            end
            LR_VCC: begin
                if (f_vlow) begin
                    lr_nxt = LR_WON;
                end
            end
            LR_WON: begin
                if (f_von) begin
                    lr_nxt = LR_RUN;
                end
            end
            default: lr_nxt = LR_RUN;
        endcase
    end

    // state, window timer and discharge outputs
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            lr_r      <= LR_RUN;
            dis_cnt_r <= 24'h0;
            x2_r      <= 1'h0;
            sink_r    <= 1'h0;
        end else begin
            lr_r      <= lr_nxt;
            dis_cnt_r <= (lr_nxt != lr_r) ? 24'h0 : inc_sat(dis_cnt_r);
            x2_r      <= (lr_nxt == LR_X2);
            sink_r    <= (lr_nxt == LR_VCC);
        end
    end

    assign avs_readdata    = rdata_r;
    assign avs_waitrequest = wait_r;
    assign drive_en        = drv_r;
    assign low_duty        = low_duty_r;
    assign pullup_en       = pullup_r;
    assign regulation_ok   = reg_ok_r;
    assign x2_discharge    = x2_r;
    assign supply_sink     = sink_r;

    // ---- checks
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence lr_expire_s;
        lr_r == LR_RUN && rmv_cnt_r >= RMV_L && !pos_w;
    endsequence

    gnd_stop_a: assert property (
        f_gnd && gnd_cnt_r >= GND_L |=> gnd_fault_r ##1 !drv_r)
        else $error("open ground did not stop drive");
    rail_off_a: assert property (
        f_rail |=> !drv_r)
        else $error("drive with sense pin at rail");
    pullup_on_a: assert property (
        $rose(pullup_r) |-> $past(wd_cnt_r) == WD_L)
        else $error("pull-up not tied to watchdog expiry");
    arm_gate_a: assert property (
        !armed_r |=> !drv_r)
        else $error("drive while unarmed");
    low_duty_a: assert property (
        f_ovs |=> low_duty_r)
        else $error("low duty not forced");
    flt_blank_a: assert property (
        $rose(fault_latch_r) |-> $past(flt_cnt_r) >= FLT_L)
        else $error("fault latched before blanking");
    latch_hold_a: assert property (
        fault_latch_r && !f_bo && !f_vrst |=> fault_latch_r)
        else $error("fault latch cleared early");
    stby_gate_a: assert property (
        !reg_ok_r |=> !stby_act_r)
        else $error("standby without regulation ok");
    stby_blank_a: assert property (
        $rose(reg_ok_r) |=> !stby_act_r [*2])
        else $error("standby inside blank time");
    burst_end_a: assert property (
        burst_off_r && f_blow |=> !burst_off_r)
        else $error("burst off did not end");
    removal_a: assert property (
        lr_expire_s |=> lr_r == LR_X2 && x2_r ##1 !reg_ok_r && !drv_r)
        else $error("line removal not acted on");
    x2_return_a: assert property (
        lr_r == LR_X2 && pos_w |=> lr_r == LR_VCC && sink_r)
        else $error("line return did not start sink");
    sink_end_a: assert property (
        sink_r && f_vlow |=> !sink_r)
        else $error("supply sink not released");
    restart_a: assert property (
        lr_r == LR_WON |=> !drv_r)
        else $error("restart before turn-on level");
endmodule

// *** test/pfss_far_side.sv ***
`timescale 1ns/1ps
// ac line, filter capacitor and supply capacitor, behavioural
module pfss_far_side (
    input  wire logic       clk,          // bench clock
    input  wire logic       reset_n,      // sync reset
    input  wire logic       line_present, // ac line applied
    input  wire logic       x2_discharge, // filter cap discharge
    input  wire logic       supply_sink,  // supply cap sink
    output logic [9:0]      line_code,    // line sample value
    output logic            x2_low,       // filter cap below 30 V
    output logic            supply_low,   // supply below 5 V
    output logic            supply_on     // supply at turn-on
);
    logic [12:0] ph_r;  // line phase, rises between samples
    logic [10:0] x2_r;  // discharge cycles spent on filter cap
    logic [7:0]  vcc_r; // supply capacitor level, 200 = full
    // line ramps up and wraps every 8192 cycles while present, collapses to zero when removed
    always_ff @(posedge clk) begin
        if (!reset_n || !line_present) begin
            ph_r <= 13'h0;
        end else begin
            ph_r <= ph_r + 13'h1;
        end
    end
    // filter cap needs 2000 cycles of discharge, longer than one window
    always_ff @(posedge clk) begin
        if (!reset_n || line_present) begin
            x2_r <= 11'h0;
        end else if (x2_discharge && x2_r < 11'd2000) begin
            x2_r <= x2_r + 11'h1;
        end
    end
    // supply drains under the sink, recharges when released
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            vcc_r <= 8'd200;
        end else if (supply_sink && vcc_r != 8'h0) begin
            vcc_r <= vcc_r - 8'h1;
        end else if (!supply_sink && vcc_r < 8'd200) begin
            vcc_r <= vcc_r + 8'h1;
        end
    end
    assign line_code  = ph_r[12:3];
    assign x2_low     = (x2_r >= 11'd2000);
    assign supply_low = (vcc_r < 8'd20);
    assign supply_on  = (vcc_r >= 8'd150);
endmodule

// *** test/pfss_top_tb_top.sv ***
`timescale 1ns/1ps
module pfss_top_tb_top;
    logic clk, reset_n, rd, wr, wait_n, line_present;
    logic [3:0] addr;
    logic [31:0] wdata, rdata, s;
    logic gnd, rail, arm, ovs, flt, stby, brst, ota, buv, bro, srst, uv;
    logic drive_en, low_duty, pullup_en, regulation_ok, x2_dis, sink;
    logic x2_low, supply_low, supply_on;
    logic [9:0] line_code;
    int errors = 0, num_checks = 0, cycles = 0;
    pfss_top #(.BLANK_CYC(50), .RMV_CYC(4000), .DIS_CYC(1500)) dut (
        .clk(clk), .reset_n(reset_n), .avs_address(addr),
        .avs_read(rd), .avs_write(wr), .avs_writedata(wdata),
        .avs_byteenable(4'hf), .avs_readdata(rdata),
        .avs_waitrequest(wait_n), .gnd_diode_cur(gnd),
        .sense_at_rail(rail), .sense_above_arm(arm), .overstress(ovs),
        .fault_above_thr(flt), .standby_below(stby),
        .bulk_below_rst(brst), .ota_in_reg(ota), .bulk_above_uv(buv),
        .brownout(bro), .supply_reset(srst), .supply_on(supply_on),
        .supply_low(supply_low), .x2_low(x2_low), .uvlo(uv),
        .line_code(line_code), .drive_en(drive_en), .low_duty(low_duty),
        .pullup_en(pullup_en), .regulation_ok(regulation_ok),
        .x2_discharge(x2_dis), .supply_sink(sink));
    pfss_far_side far (
        .clk(clk), .reset_n(reset_n), .line_present(line_present),
        .x2_discharge(x2_dis), .supply_sink(sink), .line_code(line_code),
        .x2_low(x2_low), .supply_low(supply_low), .supply_on(supply_on));
    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // one avalon access, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        addr  <= a;
        wr    <= w;
        rd    <= !w;
        wdata <= d;
        @(posedge clk);
        while (wait_n !== 1'b0) @(posedge clk);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic stat();
        bus(1'b0, 4'h4, 32'h0, s);
    endtask
    // registers, unmapped place, line state after reset
    task automatic t_regs();
        bus(1'b0, 4'h0, 32'h0, s);
        chk(s, 32'h1);
        bus(1'b1, 4'hc, 32'h0, s);
        bus(1'b0, 4'hc, 32'h0, s);
        chk(s, 32'h0);
        bus(1'b0, 4'h0, 32'h0, s);
        chk(s, 32'h1);
        stat();
        chk(s[14:10], 5'h01);
        $display("test regs done");
    endtask
    // regulation ok, then standby blanked for 50 cycles
    task automatic t_standby();
        ota <= 1'b1;
        buv <= 1'b1;
        cyc(10);
        chk(regulation_ok, 1'b1);
        stby <= 1'b1;
        cyc(10);
        stat();
        chk(s[8], 1'b0);
        cyc(60);
        stat();
        chk(s[8], 1'b1);
        chk(s[9], 1'b1);
        // bulk sags below restart: burst off ends, stays on until in reg
        ota  <= 1'b0;
        brst <= 1'b1;
        cyc(8);
        stat();
        chk(s[9], 1'b0);
        ota  <= 1'b1;
        brst <= 1'b0;
        cyc(8);
        stat();
        chk(s[9], 1'b1);
        stby <= 1'b0;
        cyc(10);
        $display("test standby done");
    endtask
    task automatic t_overstress();
        ovs <= 1'b1;
        cyc(8);
        chk(low_duty, 1'b1);
        ovs <= 1'b0;
        cyc(8);
        chk(low_duty, 1'b0);
        $display("test overstress done");
    endtask
    // short excursion ignored, long one latches, brownout clears
    task automatic t_fault();
        flt <= 1'b1;
        cyc(200);
        flt <= 1'b0;
        cyc(10);
        stat();
        chk(s[4], 1'b0);
        flt <= 1'b1;
        cyc(400);
        flt <= 1'b0;
        cyc(10);
        stat();
        chk(s[4], 1'b1);
        chk(drive_en, 1'b0);
        bro <= 1'b1;
        cyc(10);
        bro <= 1'b0;
        cyc(10);
        stat();
        chk(s[4], 1'b0);
        $display("test fault done");
    endtask
    // no arm edge for over 2000 cycles raises the pull-up
    task automatic t_watchdog();
        cyc(2100);
        chk(pullup_en, 1'b1);
        chk(drive_en, 1'b0);
        arm <= 1'b1;
        cyc(10);
        stat();
        chk(s[7], 1'b1);
        chk(drive_en, 1'b1);
        // open sense pin, then software disable, both stop the drive
        rail <= 1'b1;
        cyc(8);
        chk(drive_en, 1'b0);
        rail <= 1'b0;
        bus(1'b1, 4'h0, 32'h0, s);
        cyc(2);
        chk(drive_en, 1'b0);
        bus(1'b0, 4'h0, 32'h0, s);
        chk(s, 32'h0);
        bus(1'b1, 4'h0, 32'h1, s);
        cyc(8);
        chk(drive_en, 1'b1);
        arm <= 1'b0;
        $display("test watchdog done");
    endtask
    task automatic t_ground();
        gnd <= 1'b1;
        cyc(2100);
        stat();
        chk(s[5], 1'b1);
        chk(drive_en, 1'b0);
        gnd  <= 1'b0;
        srst <= 1'b1;
        cyc(10);
        srst <= 1'b0;
        cyc(10);
        stat();
        chk(s[5], 1'b0);
        $display("test ground done");
    endtask
    // removal, two discharge windows, supply sink, wait for turn-on
    task automatic t_line();
        int n = 0;
        line_present <= 1'b0;
        while (x2_dis !== 1'b1) @(posedge clk);
        cyc(2);
        chk(regulation_ok, 1'b0);
        chk(drive_en, 1'b0);
        cyc(1505);
        stat();
        chk(s[14:10], 5'h04);
        while (sink !== 1'b1) @(posedge clk);
        while (sink !== 1'b0) @(posedge clk);
        stat();
        chk(s[14:10], 5'h10);
        line_present <= 1'b1;
        cyc(200);
        stat();
        chk(s[14:10], 5'h01);
        // line back inside a discharge window goes straight to sink
        line_present <= 1'b0;
        while (x2_dis !== 1'b1) @(posedge clk);
        line_present <= 1'b1;
        while (sink !== 1'b1) begin
            @(posedge clk);
            n++;
        end
        chk(n < 1500, 1'b1);
        stat();
        chk(s[14:10], 5'h08);
        $display("test line done");
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            errors++;
            print_verdict();
        end
    end
    initial begin
        {reset_n, rd, wr, gnd, rail, arm, ovs, flt, stby} = '0;
        {brst, ota, buv, bro, srst, uv} = '0;
        addr = 4'h0;
        wdata = 32'h0;
        line_present = 1'b1;
        cyc(5);
        reset_n <= 1'b1;
        cyc(5);
        t_regs();
        t_standby();
        t_overstress();
        t_fault();
        t_watchdog();
        t_ground();
        t_line();
        print_verdict();
    end
endmodule
